// ---- common/aac_pkg.sv ----
// aac_pkg: constants and types of the alert comparator control block
// assumes one 10 MHz clock; register access arrives from I2C framing logic
// Overview of operation
// - rate_select picks 128 to 3300 samples/s; 110b and 111b both give 3300
// - comparator style bit: 0 traditional threshold, 1 window
// - alert_polarity 0 makes the alert pin active low, 1 active high
// - hold bit 0: alert drops on a result below the lower limit (traditional) or inside the limits (window)
// - hold bit 1: alert stays until conversion data read or alert response
// - alert response: answer own address; lowest asserting address wins
// - fault_count_sel 11b disables comparator and floats the alert pin
// - otherwise alert after 1, 2 or 4 successive out-of-limit results
// - lower and upper limits are 16-bit two's complement, value in 15:4
// - upper MSB 1 with lower MSB 0 turns the pin into a ready output
// - ready mode, single shot: pin shows the conv_state bit
// - ready mode, continuous: pin pulses after each finished conversion
// - conv_state reads 0 while converting and 1 when idle
// - result register holds 12-bit result in 15:4, bits 3:0 read zero
package aac_pkg;
    // register pointers
    localparam logic [1:0] PTR_CONV = 2'h0;
    localparam logic [1:0] PTR_SETUP = 2'h1;
    localparam logic [1:0] PTR_LOWER = 2'h2;
    localparam logic [1:0] PTR_UPPER = 2'h3;
    // reset values
    localparam logic [15:0] RST_CONV = 16'h0000;
    localparam logic [15:0] RST_SETUP = 16'h8583;
    localparam logic [15:0] RST_LOWER = 16'h8000;
    localparam logic [15:0] RST_UPPER = 16'h7FFF;
    // field positions
    localparam int unsigned OS_BIT = 15;
    localparam int unsigned LIM_MSB = 15;
    localparam int unsigned VAL_LSB = 4;
    // rate codes and their sample rates
    localparam logic [2:0] RATE_128 = 3'h0;
    localparam logic [2:0] RATE_250 = 3'h1;
    localparam logic [2:0] RATE_490 = 3'h2;
    localparam logic [2:0] RATE_920 = 3'h3;
    localparam logic [2:0] RATE_1600 = 3'h4;
    localparam logic [2:0] RATE_2400 = 3'h5;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_NS = 100;
    localparam int unsigned CYC_128 = CLK_HZ / 128;
    localparam int unsigned CYC_250 = CLK_HZ / 250;
    localparam int unsigned CYC_490 = CLK_HZ / 490;
    localparam int unsigned CYC_920 = CLK_HZ / 920;
    localparam int unsigned CYC_1600 = CLK_HZ / 1600;
    localparam int unsigned CYC_2400 = CLK_HZ / 2400;
    localparam int unsigned CYC_3300 = CLK_HZ / 3300;
    // fault count encodings
    localparam logic [1:0] FAULT_ONE = 2'h0;
    localparam logic [1:0] FAULT_TWO = 2'h1;
    localparam logic [1:0] FAULT_FOUR = 2'h2;
    localparam logic [1:0] FAULT_OFF = 2'h3;
    // ready pulse width, least time so rounded up
    localparam int unsigned RDY_PULSE_NS = 8000;
    localparam logic [7:0] RDY_PULSE_CYC = 8'((RDY_PULSE_NS + CLK_NS - 1) / CLK_NS);

    typedef struct packed {
        logic conv_state;
        logic [2:0] input_sel;
        logic [2:0] gain_select;
        logic single_shot;
        logic [2:0] rate_select;
        logic comp_style;
        logic alert_polarity;
        logic alert_hold;
        logic [1:0] fault_count_sel;
    } aac_setup_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] ptr;
        logic [15:0] wdata;
    } aac_reg_req_t;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_RUN = 2'b01
    } aac_conv_state_t;
endpackage

// ---- src/aac_ctrl.sv ----
// aac_ctrl: conversion pacing, limit registers, comparator and alert pin
// assumes register strobes come from same-clock I2C framing logic and the
// analog core presents its 12-bit sample on i_adc_sample at conversion end
`timescale 1ns/1ns
module aac_ctrl #(
    parameter int unsigned P_CYC_128 = aac_pkg::CYC_128,
    parameter int unsigned P_CYC_250 = aac_pkg::CYC_250,
    parameter int unsigned P_CYC_490 = aac_pkg::CYC_490,
    parameter int unsigned P_CYC_920 = aac_pkg::CYC_920,
    parameter int unsigned P_CYC_1600 = aac_pkg::CYC_1600,
    parameter int unsigned P_CYC_2400 = aac_pkg::CYC_2400
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire aac_pkg::aac_reg_req_t i_reg,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [11:0] i_adc_sample,
    output logic o_converting,
    input wire logic [6:0] i_dev_addr,
    input wire logic i_ara_done,
    input wire logic [6:0] i_ara_win_addr,
    output logic o_ara_claim,
    output logic [6:0] o_ara_addr,
    output logic o_alert_out,
    output logic o_alert_oe
);
    import aac_pkg::*;

    // ----------------------------------------
    // reset release and address strap
    // ----------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [6:0] addr_m_r;
    logic [6:0] addr_r;

    // release is synchronous so no flop leaves reset in a different cycle
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // address pins are outside the clock domain
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_m_r <= 7'h00;
            addr_r <= 7'h00;
        end else begin
            addr_m_r <= i_dev_addr;
            addr_r <= addr_m_r;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [16:0] rate_cycles(input logic [2:0] sel);
        case (sel)
            RATE_128: rate_cycles = 17'(P_CYC_128);
            RATE_250: rate_cycles = 17'(P_CYC_250);
            RATE_490: rate_cycles = 17'(P_CYC_490);
            RATE_920: rate_cycles = 17'(P_CYC_920);
            RATE_1600: rate_cycles = 17'(P_CYC_1600);
            RATE_2400: rate_cycles = 17'(P_CYC_2400);
            default: rate_cycles = 17'(CYC_3300);
        endcase
    endfunction

    function automatic logic [3:0] fault_need(input logic [1:0] sel);
        case (sel)
            FAULT_TWO: fault_need = 4'h2;
            FAULT_FOUR: fault_need = 4'h4;
            default: fault_need = 4'h1;
        endcase
    endfunction

    // ----------------------------------------
    // register file
    // ----------------------------------------
    aac_setup_t setup_r;
    aac_setup_t setup_nxt;
    logic [15:0] lower_r;
    logic [15:0] lower_nxt;
    logic [15:0] upper_r;
    logic [15:0] upper_nxt;
    logic [15:0] conv_r;
    logic [15:0] rdata_nxt;
    logic rvalid_nxt;
    logic conv_state;

    // writes and registered reads; the stored os bit is ignored on read
    always_comb begin
        setup_nxt = setup_r;
        lower_nxt = lower_r;
        upper_nxt = upper_r;
        rdata_nxt = o_reg_rdata;
        rvalid_nxt = 1'b0;
        if (i_reg.wr) begin
            case (i_reg.ptr)
                PTR_SETUP: setup_nxt = aac_setup_t'(i_reg.wdata);
                PTR_LOWER: lower_nxt = i_reg.wdata;
                PTR_UPPER: upper_nxt = i_reg.wdata;
                default: ;
            endcase
        end
        if (i_reg.rd) begin
            rvalid_nxt = 1'b1;
            case (i_reg.ptr)
                PTR_CONV: rdata_nxt = conv_r;
                PTR_SETUP: rdata_nxt = {conv_state, 15'(setup_r)};
                PTR_LOWER: rdata_nxt = lower_r;
                default: rdata_nxt = upper_r;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_r <= aac_setup_t'(RST_SETUP);
            lower_r <= RST_LOWER;
            upper_r <= RST_UPPER;
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'b0;
        end else begin
            setup_r <= setup_nxt;
            lower_r <= lower_nxt;
            upper_r <= upper_nxt;
            o_reg_rdata <= rdata_nxt;
            o_reg_rvalid <= rvalid_nxt;
        end
    end

    // ----------------------------------------
    // conversion pacing
    // ----------------------------------------
    aac_conv_state_t cs_r;
    aac_conv_state_t cs_nxt;
    logic [16:0] cnt_r;
    logic [16:0] cnt_nxt;
    logic [15:0] conv_nxt;
    logic done;
    logic start_shot;

    // a start written while busy is dropped, the running conversion rules
    assign start_shot = i_reg.wr && (i_reg.ptr == PTR_SETUP) && i_reg.wdata[OS_BIT];
    assign conv_state = (cs_r == CS_IDLE);

    always_comb begin
        cs_nxt = cs_r;
        cnt_nxt = cnt_r;
        conv_nxt = conv_r;
        done = 1'b0;
        case (cs_r)
            CS_IDLE: begin
                if (!setup_r.single_shot || start_shot) begin
                    cs_nxt = CS_RUN;
                    cnt_nxt = 17'h00000;
                end
            end
            CS_RUN: begin
                if (cnt_r >= rate_cycles(setup_r.rate_select) - 17'h00001) begin
                    done = 1'b1;
                    cnt_nxt = 17'h00000;
                    conv_nxt = {i_adc_sample, 4'h0};
                    if (setup_r.single_shot) begin
                        cs_nxt = CS_IDLE;
                    end
                end else begin
                    cnt_nxt = cnt_r + 17'h00001;
                end
            end
            default: cs_nxt = CS_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_r <= CS_IDLE;
            cnt_r <= 17'h00000;
            conv_r <= RST_CONV;
        end else begin
            cs_r <= cs_nxt;
            cnt_r <= cnt_nxt;
            conv_r <= conv_nxt;
        end
    end
    assign o_converting = (cs_r == CS_RUN);

    // ----------------------------------------
    // digital comparator
    // ----------------------------------------
    logic signed [11:0] res_s;
    logic signed [11:0] hi_s;
    logic signed [11:0] lo_s;
    logic above;
    logic below;
    logic outside;
    logic rdy_mode;
    logic cmp_off;
    logic latch_clr;
    logic trip;
    logic [2:0] fcnt_r;
    logic [2:0] fcnt_nxt;
    logic alert_r;
    logic alert_nxt;

    // raw codes are compared, so limits follow gain only if software says so
    assign res_s = $signed(i_adc_sample);
    assign hi_s = $signed(upper_r[LIM_MSB:VAL_LSB]);
    assign lo_s = $signed(lower_r[LIM_MSB:VAL_LSB]);
    assign above = res_s > hi_s;
    assign below = res_s < lo_s;
    assign outside = setup_r.comp_style ? (above || below) : above;
    assign rdy_mode = upper_r[LIM_MSB] && !lower_r[LIM_MSB];
    assign cmp_off = (setup_r.fault_count_sel == FAULT_OFF);
    // lowest address wins on the wire; only the winner is released
    assign latch_clr = setup_r.alert_hold && ((i_reg.rd && (i_reg.ptr == PTR_CONV))
        || (i_ara_done && alert_r && (i_ara_win_addr == addr_r)));

    // clear comes first so a trip in the same cycle wins
    always_comb begin
        fcnt_nxt = fcnt_r;
        alert_nxt = alert_r;
        trip = 1'b0;
        if (latch_clr) begin
            alert_nxt = 1'b0;
        end
        if (done) begin
            if (outside) begin
                fcnt_nxt = (fcnt_r == 3'h7) ? fcnt_r : fcnt_r + 3'h1;
            end else begin
                fcnt_nxt = 3'h0;
            end
            trip = outside && ({1'b0, fcnt_r} + 4'h1 >= fault_need(setup_r.fault_count_sel));
            if (trip) begin
                alert_nxt = 1'b1;
            end else if (!setup_r.alert_hold) begin
                if (setup_r.comp_style ? !outside : below) begin
                    alert_nxt = 1'b0;
                end
            end
        end
        if (cmp_off || rdy_mode) begin
            alert_nxt = 1'b0;
            fcnt_nxt = 3'h0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fcnt_r <= 3'h0;
            alert_r <= 1'b0;
        end else begin
            fcnt_r <= fcnt_nxt;
            alert_r <= alert_nxt;
        end
    end

    // the response port answers with the strapped address while asserting
    assign o_ara_claim = alert_r;
    assign o_ara_addr = addr_r;

    // ----------------------------------------
    // alert / ready pin
    // ----------------------------------------
    logic [7:0] pulse_r;
    logic [7:0] pulse_nxt;
    logic act;
    logic pin_nxt;
    logic oe_nxt;

    always_comb begin
        pulse_nxt = pulse_r;
        if (done && rdy_mode && !setup_r.single_shot) begin
            pulse_nxt = RDY_PULSE_CYC;
        end else if (pulse_r != 8'h00) begin
            pulse_nxt = pulse_r - 8'h01;
        end
        if (rdy_mode) begin
            act = setup_r.single_shot ? conv_state : (pulse_r != 8'h00);
        end else begin
            act = alert_r;
        end
        pin_nxt = setup_r.alert_polarity ? act : !act;
        oe_nxt = !cmp_off;
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_r <= 8'h00;
            o_alert_out <= 1'b1;
            o_alert_oe <= 1'b0;
        end else begin
            pulse_r <= pulse_nxt;
            o_alert_out <= pin_nxt;
            o_alert_oe <= oe_nxt;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    a_rate_period: assert property (done |-> cnt_r == rate_cycles(setup_r.rate_select) - 17'h00001)
        else $error("conversion ended off its rate period");
    a_off_floats: assert property (cmp_off |=> !o_alert_oe)
        else $error("alert pin driven while comparator disabled");
    a_pin_active: assert property (alert_r && !rdy_mode |=> o_alert_out == $past(setup_r.alert_polarity))
        else $error("asserted alert shows wrong level");
    a_pin_idle: assert property (!alert_r && !rdy_mode |=> o_alert_out != $past(setup_r.alert_polarity))
        else $error("idle alert shows active level");
    a_single_trip: assert property (done && outside && !cmp_off && !rdy_mode
        && setup_r.fault_count_sel == FAULT_ONE |=> alert_r)
        else $error("one-fault setting did not assert");
    a_four_count: assert property ($rose(alert_r) && $past(setup_r.fault_count_sel) == FAULT_FOUR
        |-> $past(fcnt_r) >= 3'h3)
        else $error("alert before four faults");
    a_hold_stays: assert property (alert_r && setup_r.alert_hold && !latch_clr && !cmp_off && !rdy_mode
        && !i_reg.wr |=> alert_r)
        else $error("held alert dropped without clear");
    a_read_clears: assert property (alert_r && setup_r.alert_hold && i_reg.rd && i_reg.ptr == PTR_CONV
        && !done |=> !alert_r)
        else $error("result read did not clear held alert");
    a_window_release: assert property (done && !setup_r.alert_hold && setup_r.comp_style && !outside
        |=> !alert_r)
        else $error("window alert not released inside limits");
    a_ara_release: assert property (i_ara_done && alert_r && setup_r.alert_hold && i_ara_win_addr == addr_r
        && !done |=> !alert_r)
        else $error("winning responder kept its alert");
    a_state_read: assert property (i_reg.rd && i_reg.ptr == PTR_SETUP |=> o_reg_rdata[OS_BIT] == $past(conv_state))
        else $error("conv_state read wrong");
    a_rdy_pulse: assert property (done && rdy_mode && !setup_r.single_shot && !cmp_off |=> ##1
        o_alert_out == $past(setup_r.alert_polarity, 2))
        else $error("no ready pulse after conversion");

    c_hold_read: cover property (alert_r && setup_r.alert_hold ##[1:20] !alert_r);
    c_window_trip: cover property (done && setup_r.comp_style && below && alert_nxt);
    c_rdy_pulse: cover property (done && rdy_mode && !setup_r.single_shot);
    c_ara_win: cover property (i_ara_done && latch_clr);
endmodule

// ---- dv/aac_host_model.sv ----
// aac_host_model: register controller, analog core and alert-response framing stand-in
// assumes one-cycle same-clock register strobes as the package request type carries
`timescale 1ns/1ns
module aac_host_model (
    input wire logic i_sys_clk,
    input wire logic [15:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    output aac_pkg::aac_reg_req_t o_reg,
    output logic [11:0] o_sample,
    output logic o_ara_done,
    output logic [6:0] o_ara_win_addr
);
    import aac_pkg::*;
    // ------
    // idle levels
    // ------
    initial begin
        o_reg = '0;
        o_sample = 12'h000;
        o_ara_done = 1'b0;
        o_ara_win_addr = 7'h00;
    end
    // one-cycle strobe; released lines carry the inverse so stale data never looks valid
    task automatic put(input logic wr, input logic rd, input logic [1:0] ptr, input logic [15:0] d);
        @(posedge i_sys_clk);
        o_reg <= '{wr: wr, rd: rd, ptr: ptr, wdata: d};
        @(posedge i_sys_clk);
        o_reg <= '{wr: 1'b0, rd: 1'b0, ptr: ~ptr, wdata: ~d};
    endtask
    task automatic write(input logic [1:0] ptr, input logic [15:0] d);
        put(1'b1, 1'b0, ptr, d);
    endtask
    // read data stands exactly one cycle after the strobe edge
    task automatic read(input logic [1:0] ptr, output logic [15:0] d);
        put(1'b0, 1'b1, ptr, 16'h0000);
        @(negedge i_sys_clk);
        d = i_reg_rvalid ? i_reg_rdata : 16'hXXXX;
    endtask
    // limits go as a pair, upper above lower, after any gain change
    task automatic set_limits(input logic [15:0] lo, input logic [15:0] hi);
        write(PTR_LOWER, lo);
        write(PTR_UPPER, hi);
    endtask
    task automatic set_sample(input logic [11:0] s);
        @(posedge i_sys_clk);
        o_sample <= s;
    endtask
    // arbitration result pulse; address line flips once released
    task automatic ara(input logic [6:0] a);
        @(posedge i_sys_clk);
        o_ara_done <= 1'b1;
        o_ara_win_addr <= a;
        @(posedge i_sys_clk);
        o_ara_done <= 1'b0;
        o_ara_win_addr <= ~a;
    endtask
endmodule

// ---- dv/adc_alert_comparator_ctrl_tb_top.sv ----
// adc_alert_comparator_ctrl_tb_top: self-checking bench for aac_ctrl
// assumes aac_host_model as controller; short conversion periods keep the run brief
`timescale 1ns/1ns
module adc_alert_comparator_ctrl_tb_top;
    import aac_pkg::*;
    localparam logic [6:0] OWN_ADDR = 7'h2A; // arbitrary strap value
    localparam int TIME_LIMIT = 30000;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    aac_reg_req_t reg_req;
    logic [15:0] rdata;
    logic rvalid;
    logic [11:0] sample;
    logic converting;
    logic ara_done;
    logic [6:0] ara_win;
    logic ara_claim;
    logic [6:0] ara_addr;
    logic alert_out;
    logic alert_oe;
    logic [6:0] strap = OWN_ADDR;
    logic [14:0] cfg = 15'h0583;
    logic [15:0] rd;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    int need;
    int exp_n[8] = '{40, 50, 60, 70, CYC_1600, 200, CYC_3300, CYC_3300};

    // ------
    // clock, parts
    // ------
    always #50 i_sys_clk = ~i_sys_clk;

    aac_host_model host (
        .i_sys_clk(i_sys_clk),
        .i_reg_rdata(rdata),
        .i_reg_rvalid(rvalid),
        .o_reg(reg_req),
        .o_sample(sample),
        .o_ara_done(ara_done),
        .o_ara_win_addr(ara_win)
    );

    // rate 100b keeps its full default period so the package count is exercised too
    aac_ctrl #(.P_CYC_128(40), .P_CYC_250(50), .P_CYC_490(60), .P_CYC_920(70),
        .P_CYC_2400(200)) DUT (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_reg(reg_req),
        .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid),
        .i_adc_sample(sample),
        .o_converting(converting),
        .i_dev_addr(strap),
        .i_ara_done(ara_done),
        .i_ara_win_addr(ara_win),
        .o_ara_claim(ara_claim),
        .o_ara_addr(ara_addr),
        .o_alert_out(alert_out),
        .o_alert_oe(alert_oe)
    );

    // ------
    // helpers
    // ------
    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [14:0] mk(input logic single, input logic [2:0] rate, input logic style,
        input logic pol, input logic hold, input logic [1:0] fault);
        return {3'h0, 3'h2, single, rate, style, pol, hold, fault};
    endfunction
    // pin level follows the polarity bit held in cfg
    task automatic pin(input logic active);
        check1("alert pin", active ? cfg[3] : ~cfg[3], alert_out);
        check1("alert enable", 1'b1, alert_oe);
    endtask
    // bounded waits; n ends as the number of cycles spent
    task automatic wait_conv(input logic level);
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (converting !== level && n < 7000);
    endtask
    task automatic wait_pin(input logic active);
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (alert_out !== (active ? cfg[3] : ~cfg[3]) && n < 1000);
    endtask
    task automatic convert(input logic [11:0] s);
        host.set_sample(s);
        host.write(PTR_SETUP, {1'b1, cfg});
        wait_conv(1'b1);
        wait_conv(1'b0);
        repeat (3) @(negedge i_sys_clk);
    endtask

    // hang guard: a run past the limit counts as a mismatch
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == TIME_LIMIT) begin
            miscompares++;
            give_verdict();
        end
    end

    // ------
    // tests
    // ------
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check1("alert enable", 1'b0, alert_oe);
        check16("strap address", {9'h000, OWN_ADDR}, {9'h000, ara_addr});
        // strap pins may move at run time; the synchronised copy follows two edges later
        @(posedge i_sys_clk);
        strap <= 7'h35;
        repeat (3) @(negedge i_sys_clk);
        check16("strap address", {9'h000, 7'h35}, {9'h000, ara_addr});
        host.read(PTR_SETUP, rd);
        check16("setup", 16'h8583, rd);
        host.read(PTR_LOWER, rd);
        check16("lower limit", 16'h8000, rd);
        host.read(PTR_UPPER, rd);
        check16("upper limit", 16'h7FFF, rd);
        host.write(PTR_CONV, 16'hFFFF);
        host.read(PTR_CONV, rd);
        check16("result", 16'h0000, rd);
        host.write(PTR_LOWER, 16'hA5C3);
        host.read(PTR_LOWER, rd);
        check16("lower limit", 16'hA5C3, rd);
        $display("test registers done");
        // every rate code, period measured on the busy level
        for (int r = 0; r < 8; r++) begin
            cfg = mk(1'b1, 3'(r), 1'b0, 1'b0, 1'b0, 2'h3);
            host.set_sample(12'(16 * r + 5));
            host.write(PTR_SETUP, {1'b1, cfg});
            wait_conv(1'b1);
            wait_conv(1'b0);
            check16("period", 16'(exp_n[r]), 16'(n));
            host.read(PTR_CONV, rd);
            check16("result", {12'(16 * r + 5), 4'h0}, rd);
        end
        host.write(PTR_SETUP, {1'b1, cfg});
        host.read(PTR_SETUP, rd);
        check16("busy setup", {1'b0, cfg}, rd);
        wait_conv(1'b0);
        host.read(PTR_SETUP, rd);
        check16("idle setup", {1'b1, cfg}, rd);
        $display("test rates done");
        // traditional style keeps the alert between the limits
        cfg = mk(1'b1, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0);
        host.write(PTR_SETUP, {1'b0, cfg});
        host.set_limits(16'h1000, 16'h3000);
        convert(12'h400);
        pin(1'b1);
        convert(12'h200);
        pin(1'b1);
        convert(12'h080);
        pin(1'b0);
        cfg[3] = 1'b1;
        convert(12'h400);
        pin(1'b1);
        // window style, then fault counts of two and four
        cfg = mk(1'b1, 3'h0, 1'b1, 1'b0, 1'b0, 2'h0);
        convert(12'h080);
        pin(1'b1);
        convert(12'h200);
        pin(1'b0);
        for (int q = 1; q < 3; q++) begin
            cfg[1:0] = 2'(q);
            need = 2 * q;
            for (int k = 1; k <= need; k++) begin
                convert(12'h400);
                pin(k == need);
            end
            convert(12'h200);
        end
        // latching: cleared by a result read or a won alert response only
        cfg = mk(1'b1, 3'h0, 1'b1, 1'b0, 1'b1, 2'h0);
        convert(12'h400);
        convert(12'h200);
        pin(1'b1);
        host.read(PTR_CONV, rd);
        repeat (3) @(negedge i_sys_clk);
        pin(1'b0);
        convert(12'hF00);
        check1("claim", 1'b1, ara_claim);
        host.ara(strap ^ 7'h01);
        repeat (3) @(negedge i_sys_clk);
        pin(1'b1);
        host.ara(strap);
        repeat (3) @(negedge i_sys_clk);
        pin(1'b0);
        check1("claim", 1'b0, ara_claim);
        cfg[1:0] = 2'h3;
        convert(12'h400);
        check1("alert enable", 1'b0, alert_oe);
        check1("claim", 1'b0, ara_claim);
        $display("test comparator done");
        // ready mode: single shot shows the idle state, continuous pulses
        cfg = mk(1'b1, 3'h5, 1'b0, 1'b0, 1'b0, 2'h0);
        host.write(PTR_SETUP, {1'b0, cfg});
        host.write(PTR_LOWER, 16'h0000);
        host.write(PTR_UPPER, 16'h8000);
        repeat (3) @(negedge i_sys_clk);
        pin(1'b1);
        host.write(PTR_SETUP, {1'b1, cfg});
        wait_conv(1'b1);
        repeat (3) @(negedge i_sys_clk);
        pin(1'b0);
        wait_conv(1'b0);
        repeat (3) @(negedge i_sys_clk);
        pin(1'b1);
        cfg[8] = 1'b0;
        host.write(PTR_SETUP, {1'b0, cfg});
        wait_pin(1'b0);
        wait_pin(1'b1);
        wait_pin(1'b0);
        check16("ready pulse", 16'h0050, 16'(n));
        wait_pin(1'b1);
        check16("ready gap", 16'h0078, 16'(n));
        check1("converting", 1'b1, converting);
        cfg[8] = 1'b1;
        host.write(PTR_SETUP, {1'b0, cfg});
        $display("test ready done");
        give_verdict();
    end
endmodule
